// ==== src/dses_consts.svh ====
// constants for the stream event flag register bank
`ifndef DSES_CONSTS_SVH
`define DSES_CONSTS_SVH

`define DSES_ADDR_W 12
`define DSES_NUM_STREAMS 8
`define DSES_STREAMS_PER_REG 4
`define DSES_NUM_EVENTS 5

// byte offsets on the register bus
`define DSES_OFF_LOWER_STATUS 12'h000
`define DSES_OFF_UPPER_STATUS 12'h004
`define DSES_OFF_LOWER_CLEAR 12'h008
`define DSES_OFF_UPPER_CLEAR 12'h00c
`define DSES_OFF_LOWER_ENABLE 12'h100
`define DSES_OFF_UPPER_ENABLE 12'h104
`define DSES_OFF_SUMMARY 12'h108
`define DSES_OFF_SUMMARY_MASK 12'h10c

// first bit of each stream slot inside a status word
`define DSES_SLOT0_BASE 5'h00
`define DSES_SLOT1_BASE 5'h06
`define DSES_SLOT2_BASE 5'h10
`define DSES_SLOT3_BASE 5'h16

// event position relative to its slot base
`define DSES_EVT_FIFO_ERR 5'h00
`define DSES_EVT_DIRECT_ERR 5'h02
`define DSES_EVT_XFER_ERR 5'h03
`define DSES_EVT_HALF 5'h04
`define DSES_EVT_DONE 5'h05

// bits that may hold a flag; all others reserved
`define DSES_FLAG_MASK 32'h0f7d0f7d
`define DSES_RESET_WORD 32'h00000000
`define DSES_RESET_SUMMARY 8'h00

`define DSES_RESP_OKAY 2'h0
`define DSES_RESP_SLVERR 2'h2

`endif

// ==== src/dses_pkg.sv ====
// types shared by the stream event flag register bank
`default_nettype none

package dses_pkg;

  // one stream's event strobes, one cycle each
  typedef struct packed {
    logic fifoErr;
    logic directErr;
    logic xferErr;
    logic half;
    logic done;
  } dses_evt_s;

  // register selected by an address
  typedef enum logic [3:0] {
    SEL_NONE = 4'h0,
    SEL_LOWER_STATUS = 4'h1,
    SEL_UPPER_STATUS = 4'h2,
    SEL_LOWER_CLEAR = 4'h3,
    SEL_UPPER_CLEAR = 4'h4,
    SEL_LOWER_ENABLE = 4'h5,
    SEL_UPPER_ENABLE = 4'h6,
    SEL_SUMMARY = 4'h7,
    SEL_SUMMARY_MASK = 4'h8
  } dses_sel_e;

  typedef logic [31:0] dses_word_t;

endpackage : dses_pkg

`default_nettype wire

// ==== src/dses_event_flags.sv ====
// stream event flags, flag clear, interrupt enables and axi4-lite slave
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`include "dses_consts.svh"
`default_nettype none

// Function
// - fifo error flags at bits 0,6,16,22
// - direct mode error flags at 2,8,18,24
// - transfer error flags at 3,9,19,25
// - half transfer flags at 4,10,20,26
// - transfer complete flags at 5,11,21,27
// - flags set by hardware, cleared via clear
// - upper status at 0x04, resets to zero
// - lower clear at 0x08 clears lower flags
// - upper clear at 0x0c clears upper flags
// - writing zero to clear has no effect
// - clear registers write-only, same bit layout
// - clear registers reset value all zeros
// - lower status at 0x00, same layout
// - five enable bits per stream gate streamIrq; irq is gated by the summary mask only
module dses_event_flags (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire dses_pkg::dses_evt_s [`DSES_NUM_STREAMS-1:0] evtPulse,
  input wire logic [`DSES_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`DSES_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic [`DSES_NUM_STREAMS-1:0] streamIrq,
  output logic irq
);

  // ==========================================================
  // helper functions

  function automatic dses_pkg::dses_sel_e decodeAddr(input logic [`DSES_ADDR_W-1:0] addr);
    dses_pkg::dses_sel_e sel;
    sel = dses_pkg::SEL_NONE;
    unique case (addr)
      `DSES_OFF_LOWER_STATUS: sel = dses_pkg::SEL_LOWER_STATUS;
      `DSES_OFF_UPPER_STATUS: sel = dses_pkg::SEL_UPPER_STATUS;
      `DSES_OFF_LOWER_CLEAR: sel = dses_pkg::SEL_LOWER_CLEAR;
      `DSES_OFF_UPPER_CLEAR: sel = dses_pkg::SEL_UPPER_CLEAR;
      `DSES_OFF_LOWER_ENABLE: sel = dses_pkg::SEL_LOWER_ENABLE;
      `DSES_OFF_UPPER_ENABLE: sel = dses_pkg::SEL_UPPER_ENABLE;
      `DSES_OFF_SUMMARY: sel = dses_pkg::SEL_SUMMARY;
      `DSES_OFF_SUMMARY_MASK: sel = dses_pkg::SEL_SUMMARY_MASK;
      default: sel = dses_pkg::SEL_NONE;
    endcase
    return sel;
  endfunction

  // first bit of a stream's slot inside its status word
  function automatic logic [4:0] slotBase(input int slot);
    logic [4:0] base;
    base = `DSES_SLOT0_BASE;
    unique case (slot)
      1: base = `DSES_SLOT1_BASE;
      2: base = `DSES_SLOT2_BASE;
      3: base = `DSES_SLOT3_BASE;
      default: base = `DSES_SLOT0_BASE;
    endcase
    return base;
  endfunction

  function automatic dses_pkg::dses_word_t laneMask(input logic [3:0] strb);
    dses_pkg::dses_word_t m;
    m = '0;
    for (int b = 0; b < 4; b++)
    begin
      m[b*8 +: 8] = {8{strb[b]}};
    end
    return m;
  endfunction

  // ==========================================================
  // state

  dses_pkg::dses_word_t flags_reg [2];
  dses_pkg::dses_word_t flags_next [2];
  dses_pkg::dses_word_t enable_reg [2];
  dses_pkg::dses_word_t flagSet [2];
  dses_pkg::dses_word_t flagClr [2];
  logic [`DSES_NUM_STREAMS-1:0] summary_reg;
  logic [`DSES_NUM_STREAMS-1:0] summary_next;
  logic [`DSES_NUM_STREAMS-1:0] summaryMask_reg;
  logic [`DSES_NUM_STREAMS-1:0] streamHit;

  logic [`DSES_ADDR_W-1:0] awAddr_reg;
  logic awHeld_reg;
  dses_pkg::dses_word_t wData_reg;
  logic [3:0] wStrb_reg;
  logic wHeld_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  dses_pkg::dses_word_t rdata_reg;

  logic awTake;
  logic wTake;
  logic arTake;
  logic doWrite;
  dses_pkg::dses_sel_e wrSel;
  dses_pkg::dses_sel_e rdSel;
  dses_pkg::dses_word_t wrLanes;
  dses_pkg::dses_word_t wrBits;
  dses_pkg::dses_word_t readData;
  logic summaryReadClr;

  // ==========================================================
  // bus handshakes

  // readies drop with ce so no beat is taken while frozen
  assign awready = ce && !awHeld_reg && !bvalid_reg;
  assign wready = ce && !wHeld_reg && !bvalid_reg;
  assign arready = ce && !rvalid_reg;
  assign awTake = awvalid && awready;
  assign wTake = wvalid && wready;
  assign arTake = arvalid && arready;
  assign doWrite = ce && awHeld_reg && wHeld_reg;

  assign wrSel = decodeAddr(awAddr_reg);
  assign rdSel = decodeAddr(araddr);
  assign wrLanes = laneMask(wStrb_reg);
  assign wrBits = wData_reg & wrLanes;

  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rresp = rresp_reg;
  assign rdata = rdata_reg;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      awHeld_reg <= 1'b0;
      awAddr_reg <= '0;
    end
    else if (ce)
    begin
      if (awTake)
      begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= awaddr;
      end
      else if (doWrite)
      begin
        awHeld_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wHeld_reg <= 1'b0;
      wData_reg <= `DSES_RESET_WORD;
      wStrb_reg <= '0;
    end
    else if (ce)
    begin
      if (wTake)
      begin
        wHeld_reg <= 1'b1;
        wData_reg <= wdata;
        wStrb_reg <= wstrb;
      end
      else if (doWrite)
      begin
        wHeld_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `DSES_RESP_OKAY;
    end
    else if (ce)
    begin
      if (doWrite)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg <= (wrSel == dses_pkg::SEL_NONE) ? `DSES_RESP_SLVERR : `DSES_RESP_OKAY;
      end
      else if (bvalid_reg && bready)
      begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // event mapping and clear decode

  always_comb
  begin
    flagSet[0] = '0;
    flagSet[1] = '0;
    for (int s = 0; s < `DSES_NUM_STREAMS; s++)
    begin
      flagSet[s/4][slotBase(s%4) + `DSES_EVT_FIFO_ERR] = evtPulse[s].fifoErr;
      flagSet[s/4][slotBase(s%4) + `DSES_EVT_DIRECT_ERR] = evtPulse[s].directErr;
      flagSet[s/4][slotBase(s%4) + `DSES_EVT_XFER_ERR] = evtPulse[s].xferErr;
      flagSet[s/4][slotBase(s%4) + `DSES_EVT_HALF] = evtPulse[s].half;
      flagSet[s/4][slotBase(s%4) + `DSES_EVT_DONE] = evtPulse[s].done;
    end
  end

  // a zero bit leaves its flag alone; lanes without strobe clear nothing
  always_comb
  begin
    flagClr[0] = (doWrite && wrSel == dses_pkg::SEL_LOWER_CLEAR) ? wrBits : '0;
    flagClr[1] = (doWrite && wrSel == dses_pkg::SEL_UPPER_CLEAR) ? wrBits : '0;
  end

  // set is or-ed in after the clear, so a same-cycle event survives
  always_comb
  begin
    flags_next[0] = ((flags_reg[0] & ~flagClr[0]) | flagSet[0]) & `DSES_FLAG_MASK;
    flags_next[1] = ((flags_reg[1] & ~flagClr[1]) | flagSet[1]) & `DSES_FLAG_MASK;
  end

  // ==========================================================
  // flag and enable storage, one word each per stream group

  generate
    for (genvar r = 0; r < 2; r++)
    begin : gFlag
      always_ff @(posedge ref_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          flags_reg[r] <= `DSES_RESET_WORD;
        end
        else if (ce)
        begin
          flags_reg[r] <= flags_next[r];
        end
      end

      always_ff @(posedge ref_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          enable_reg[r] <= `DSES_RESET_WORD;
        end
        else if (ce && doWrite &&
                 wrSel == (r == 0 ? dses_pkg::SEL_LOWER_ENABLE : dses_pkg::SEL_UPPER_ENABLE))
        begin
          enable_reg[r] <= ((enable_reg[r] & ~wrLanes) | wrBits) & `DSES_FLAG_MASK;
        end
      end
    end
  endgenerate

  // ==========================================================
  // interrupts

  always_comb
  begin
    for (int s = 0; s < `DSES_NUM_STREAMS; s++)
    begin
      streamHit[s] = |evtPulse[s];
      streamIrq[s] = |(flags_reg[s/4] & enable_reg[s/4]
                       & (`DSES_FLAG_MASK >> slotBase(s%4) << slotBase(s%4))
                       & ~(`DSES_FLAG_MASK >> (slotBase(s%4) + 5'h06)
                           << (slotBase(s%4) + 5'h06)));
    end
  end

  assign summaryReadClr = arTake && rdSel == dses_pkg::SEL_SUMMARY;

  // read-clear loses to a new event in the same cycle
  assign summary_next = summaryReadClr ? streamHit : (summary_reg | streamHit);

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      summary_reg <= `DSES_RESET_SUMMARY;
    end
    else if (ce)
    begin
      summary_reg <= summary_next;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      summaryMask_reg <= `DSES_RESET_SUMMARY;
    end
    else if (ce && doWrite && wrSel == dses_pkg::SEL_SUMMARY_MASK && wStrb_reg[0])
    begin
      summaryMask_reg <= wData_reg[`DSES_NUM_STREAMS-1:0];
    end
  end

  assign irq = |(summary_reg & summaryMask_reg);

  // ==========================================================
  // read path

  always_comb
  begin
    readData = `DSES_RESET_WORD;
    unique case (rdSel)
      dses_pkg::SEL_LOWER_STATUS: readData = flags_reg[0] & `DSES_FLAG_MASK;
      dses_pkg::SEL_UPPER_STATUS: readData = flags_reg[1] & `DSES_FLAG_MASK;
      dses_pkg::SEL_LOWER_CLEAR, dses_pkg::SEL_UPPER_CLEAR: readData = `DSES_RESET_WORD;
      dses_pkg::SEL_LOWER_ENABLE: readData = enable_reg[0];
      dses_pkg::SEL_UPPER_ENABLE: readData = enable_reg[1];
      dses_pkg::SEL_SUMMARY: readData = {24'h000000, summary_reg};
      dses_pkg::SEL_SUMMARY_MASK: readData = {24'h000000, summaryMask_reg};
      dses_pkg::SEL_NONE: readData = `DSES_RESET_WORD;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rvalid_reg <= 1'b0;
      rresp_reg <= `DSES_RESP_OKAY;
      rdata_reg <= `DSES_RESET_WORD;
    end
    else if (ce)
    begin
      if (arTake)
      begin
        rvalid_reg <= 1'b1;
        rdata_reg <= readData;
        rresp_reg <= (rdSel == dses_pkg::SEL_NONE) ? `DSES_RESP_SLVERR : `DSES_RESP_OKAY;
      end
      else if (rvalid_reg && rready)
      begin
        rvalid_reg <= 1'b0;
      end
    end
  end

endmodule // dses_event_flags

`default_nettype wire

// ==== tb/dses_event_flags_monitor.sv ====
// concurrent checks on the event flag bank bus ports
`default_nettype none
module dses_event_flags_monitor (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // address of the read now answered; summary words use bits 1 and 7 too
  logic [11:0] rdAddr;
  always_ff @(posedge ref_clk)
  begin
    if (arvalid && arready)
    begin
      rdAddr <= araddr;
    end
  end
  // ==========
  // bus timing
  rd_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered next cycle");
  rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped before taken");
  ar_block_a: assert property (rvalid |-> !arready)
    else $error("read address taken while answer pending");
  wr_latency_a: assert property (awvalid && awready && wvalid && wready
    |=> !bvalid ##1 bvalid)
    else $error("write answer not two cycles after take");
  b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped before taken");
  aw_block_a: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while answer pending");
  // ==========
  // read data content
  rsv_zero_a: assert property (rvalid && rdAddr < 12'h100 |-> (rdata & 32'hf082f082) == 32'h0)
    else $error("reserved bit read as one");
  slverr_zero_a: assert property (rvalid && rresp == 2'h2 |-> rdata == 32'h0)
    else $error("refused read carries data");
  cover property (bvalid && bready);
  cover property (rvalid && rresp == 2'h2);
  cover property ($rose(irq));
endmodule // dses_event_flags_monitor
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for the stream event flag bank
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 0, resetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid, irq;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [1:0] bresp, rresp, rsp;
  logic [7:0] streamIrq;
  dses_pkg::dses_evt_s [7:0] evt = '0;
  dses_pkg::dses_word_t got, fl[2];
  int miscompares = 0, checkCount = 0, cyc = 0;
  int base[4] = '{0, 6, 16, 22};
  logic ce = 1;
  dses_event_flags dses_event_flags_inst (.ref_clk(ref_clk), .resetn(resetn), .ce(ce),
    .evtPulse(evt), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .streamIrq(streamIrq), .irq(irq));
  initial forever #12.5 ref_clk = ~ref_clk;
  // ==========
  // helpers
  function automatic int pos(int s, int e);
    return base[s % 4] + (e == 0 ? 0 : e + 1);
  endfunction
  // flags raised in one half by a strobe burst
  function automatic dses_pkg::dses_word_t hit(logic [39:0] v, int h);
    hit = 0;
    for (int s = 0; s < 4; s++)
      for (int e = 0; e < 5; e++)
        if (v[(h * 4 + s) * 5 + 4 - e]) hit[pos(s, e)] = 1;
  endfunction
  task automatic chk(string n, logic [31:0] g, logic [31:0] x);
    checkCount++;
    if (g !== x)
    begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1'($urandom);
    do
    begin
      @(posedge ref_clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (!bready) bready <= 1;
    end while (!(bvalid && bready));
    bready <= 0;
    chk("bresp", 32'(bresp), 32'h0);
  endtask
  task automatic rd(logic [11:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1'($urandom);
    do
    begin
      @(posedge ref_clk);
      if (arready) arvalid <= 0;
      if (!rready) rready <= 1;
    end while (!(rvalid && rready));
    d = rdata;
    rsp = rresp;
    rready <= 0;
  endtask
  task automatic rc(logic [11:0] a, logic [31:0] x);
    rd(a, got);
    chk("rdata", got, x);
    chk("rresp", 32'(rsp), 32'h0);
  endtask
  task automatic pulse(logic [39:0] v);
    @(posedge ref_clk);
    evt <= v;
    @(posedge ref_clk);
    evt <= '0;
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      miscompares++;
      report_and_stop();
    end
  end
  // ==========
  // scenarios
  initial
  begin
    logic [39:0] v;
    logic [31:0] c, m;
    int h;
    void'($urandom(32'hed00));
    repeat (5) @(posedge ref_clk);
    resetn <= 1;
    for (int a = 0; a < 16; a += 4) rc(12'(a), 32'h0);
    rd(12'h020, got);
    chk("unmapped", 32'(rsp), 32'h2);
    for (int s = 0; s < 8; s++)
      for (int e = 0; e < 5; e++)
      begin
        h = s / 4;
        m = 32'h1 << pos(s, e);
        pulse(40'h1 << (s * 5 + 4 - e));
        rc(12'(h * 4), m);
        wr(12'(8 + h * 4), ~m);
        rc(12'(h * 4), m);
        wr(12'(8 + h * 4), m);
        rc(12'(h * 4), 32'h0);
      end
    // event strobe only on the edge that applies its clear: the set must win
    fork
      wr(12'h8, 32'h1 << pos(0, 0));
      begin
        do @(posedge ref_clk); while (!(awvalid && awready));
        evt <= 40'h1 << 4;
        @(posedge ref_clk);
        evt <= '0;
      end
    join
    rc(12'h0, 32'h1);
    wr(12'h8, 32'h1);
    // frozen by ce: a strobe in that time is lost
    ce <= 0;
    pulse(40'h1 << 4);
    ce <= 1;
    rc(12'h0, 32'h0);
    fl[0] = 0;
    fl[1] = 0;
    repeat (30)
    begin
      v = 40'({$urandom, $urandom});
      pulse(v);
      fl[0] |= hit(v, 0);
      fl[1] |= hit(v, 1);
      h = $urandom % 2;
      c = $urandom;
      wr(12'(8 + h * 4), c);
      fl[h] &= ~c;
      wr(12'(h * 4), $urandom);
      rc(12'h0, fl[0]);
      rc(12'h4, fl[1]);
    end
    // interrupt: raise, mask, clear
    wr(12'h8, '1);
    wr(12'hc, '1);
    rd(12'h108, got);
    wr(12'h104, 32'h1 << pos(5, 4));
    pulse(40'h1 << 25);
    @(posedge ref_clk);
    chk("streamIrq", 32'(streamIrq), 32'h20);
    chk("irq masked", 32'(irq), 32'h0);
    wr(12'h10c, 32'hff);
    chk("irq", 32'(irq), 32'h1);
    rc(12'h108, 32'h20);
    chk("irq cleared", 32'(irq), 32'h0);
    wr(12'hc, 32'h1 << pos(5, 4));
    pulse(40'h1 << 29);
    @(posedge ref_clk);
    chk("streamIrq off", 32'(streamIrq), 32'h0);
    report_and_stop();
  end
endmodule // tb
bind dses_event_flags dses_event_flags_monitor dses_event_flags_monitor_inst (
  .ref_clk(ref_clk), .resetn(resetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
  .rdata(rdata), .rresp(rresp), .irq(irq), .araddr(araddr));
`default_nettype wire
